/* dv/init_link_props.sv */
// Checker for the command link between the initialization controller and the device
`timescale 1ns/10ps
`default_nettype none
module init_link_props (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  clk_en,
    input  wire logic                  chip_sel,
    input  wire init_seq_pkg::cmd_type cmd,
    input  wire logic [7:0]            mode_addr,
    input  wire logic [7:0]            mode_data,
    input  wire logic                  termination_control,
    input  wire logic [7:0]            read_data,
    input  wire logic                  read_valid,
    input  wire logic                  out_en,
    input  wire logic                  burst_busy
);
    import init_seq_pkg::*;
    localparam int LOW_MIN = (POST_RAMP_LOW_CYC > STABLE_CLOCK_CYC) ? POST_RAMP_LOW_CYC : STABLE_CLOCK_CYC;
    logic [12:0] low_cnt;
    logic [12:0] en_cnt;
    logic [12:0] rst_cnt;
    logic [12:0] init_cnt;
    logic [12:0] cal_cnt;
    logic        flag_seen;
    wire  logic  go      = clk_en && chip_sel;
    wire  logic  rst_cmd = go && cmd == CMD_MRW && mode_addr == MR_RESET;
    wire  logic  cal_cmd = go && cmd == CMD_MRW && mode_addr == MR_CALIBRATION;
    // Cycle counters that time each phase of the sequence from the link alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_cnt   <= '0;
            en_cnt    <= '0;
            rst_cnt   <= '0;
            init_cnt  <= '1;
            cal_cnt   <= '0;
            flag_seen <= 1'b0;
        end else begin
            low_cnt   <= clk_en ? '0 : low_cnt + 13'(low_cnt != '1);
            en_cnt    <= clk_en ? en_cnt + 13'(en_cnt != '1) : '0;
            rst_cnt   <= rst_cmd ? 13'(POST_RESET_CYC) : rst_cnt - 13'(rst_cnt != '0);
            init_cnt  <= rst_cmd ? '0 : init_cnt + 13'(init_cnt != '1);
            cal_cnt   <= rst_cmd ? '0 : cal_cmd ? 13'h0001 : cal_cnt + 13'(cal_cnt != '0 && cal_cnt != '1);
            flag_seen <= rst_cmd ? 1'b0 : flag_seen | (read_valid & ~read_data[AUTO_INIT_FLAG_BIT]);
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    outputs_off_a: assert property (!clk_en |=> !out_en)
        else $error("outputs driven while clock enable low");
    low_time_a: assert property ($rose(clk_en) |-> low_cnt >= LOW_MIN)
        else $error("clock enable rose too early");
    first_nop_a: assert property (clk_en && en_cnt < FIRST_NOP_CYC |-> !chip_sel || cmd == CMD_NOP)
        else $error("command inside first no-operation interval");
    termination_static_a: assert property (clk_en |=> $stable(termination_control))
        else $error("termination moved");
    reset_quiet_a: assert property (rst_cnt != 0 |-> clk_en && (!chip_sel || cmd == CMD_NOP))
        else $error("command inside post-reset wait");
    read_answer_a: assert property (go && cmd == CMD_MRR |=> read_valid && read_data[7:1] == 7'h00)
        else $error("read unanswered");
    flag_clear_a: assert property (read_valid && init_cnt > AUTO_INIT_MAX_CYC + 1 |->
        !read_data[AUTO_INIT_FLAG_BIT]) else $error("auto init flag still set");
    init_phase_a: assert property (go && init_cnt < AUTO_INIT_MAX_CYC && !flag_seen |->
        cmd inside {CMD_NOP, CMD_MRR, CMD_PD_ENTRY, CMD_PD_EXIT}) else $error("bad command before idle");
    cal_after_init_a: assert property (cal_cmd |->
        (flag_seen || init_cnt >= AUTO_INIT_MAX_CYC) && mode_data == CAL_INIT_CODE)
        else $error("calibration too early or wrong code");
    cal_wait_a: assert property (go && cmd == CMD_MRW && mode_addr == MR_FEATURE1 |->
        cal_cnt >= INITIAL_CAL_CYC) else $error("feature write before calibration time");
    cover property (rst_cmd);
    cover property (cal_cmd);
    cover property (read_valid && !read_data[AUTO_INIT_FLAG_BIT]);
endmodule
`default_nettype wire

/* dv/sdram_powerup_init_sequence_bench.sv */
// Testbench joining controller and device ends through the command link
`timescale 1ns/10ps
`default_nettype none
module sdram_powerup_init_sequence_bench;
    import init_seq_pkg::*;
    logic       clk;
    logic       rst;
    logic       supplies_ok;
    logic       restart;
    logic       need_training;
    logic       training_done;
    logic       cal_grant;
    logic [7:0] fv [3] = '{8'h5A, 8'hC3, 8'h0F};
    logic       in_idle, ready, all_precharged, in_training, in_training_phase, cal_busy, init_done;
    logic       odt0;
    int         mismatches = 0;
    int         num_checks = 0;
    init_link_if link();
    init_device init_device_i (.clk(clk), .rst(rst), .link(link), .in_idle(in_idle), .ready(ready),
        .all_precharged(all_precharged), .in_training(in_training));
    init_controller init_controller_i (.clk(clk), .rst(rst), .supplies_ok(supplies_ok), .restart(restart),
        .need_training(need_training), .training_done(training_done), .cal_grant(cal_grant),
        .feature1_val(fv[0]), .feature2_val(fv[1]), .io_config_val(fv[2]), .link(link),
        .in_training_phase(in_training_phase), .cal_busy(cal_busy), .init_done(init_done));
    init_link_props init_link_props_i (.clk(clk), .rst(rst), .clk_en(link.clk_en), .chip_sel(link.chip_sel),
        .cmd(link.cmd), .mode_addr(link.mode_addr), .mode_data(link.mode_data),
        .termination_control(link.termination_control), .read_data(link.read_data), .read_valid(link.read_valid),
        .out_en(link.out_en), .burst_busy(link.burst_busy));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic summarize();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic go();
        return link.clk_en && link.chip_sel && link.cmd != CMD_NOP;
    endfunction
    // Waits at falling edges for the next real command; n counts the cycles waited
    task automatic next_cmd(input int limit, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (go() !== 1'b1 && n < limit);
        if (go() !== 1'b1) begin
            chk(1'b0, 1'b1);
            summarize();
        end
    endtask
    task automatic wait_hi(input int which, input int limit, output int n);
        n = 0;
        while ((which == 0 ? in_idle : init_done) !== 1'b1 && n < limit) begin
            @(negedge clk);
            n++;
        end
        if (n >= limit) begin
            chk(1'b0, 1'b1);
            summarize();
        end
    endtask
    task automatic power_up();
        int n;
        repeat (20) begin
            @(negedge clk);
            chk(link.clk_en, 1'b0);
            chk(link.out_en, 1'b0);
        end
        supplies_ok = 1'b1;
        n = 0;
        while (link.clk_en !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (link.clk_en !== 1'b1) begin
            chk(1'b0, 1'b1);
            summarize();
        end
        chk(n >= STABLE_CLOCK_CYC && n >= POST_RAMP_LOW_CYC && n < 50, 1'b1);
        odt0 = link.termination_control;
        next_cmd(FIRST_NOP_CYC + 100, n);
        chk(n >= FIRST_NOP_CYC, 1'b1);
        chk({link.cmd, link.mode_addr}, {CMD_MRW, MR_RESET});
    endtask
    task automatic auto_init();
        int n;
        int m;
        next_cmd(400, n);
        chk(n >= POST_RESET_CYC, 1'b1);
        chk({link.cmd, link.mode_addr}, {CMD_MRR, MR_DEVICE_INFO});
        @(negedge clk);
        chk({link.read_valid, link.read_data[7:1]}, 8'h80);
        wait_hi(0, 400, m);
        chk(n + m + 1 <= AUTO_INIT_MAX_CYC + 2, 1'b1);
        chk(all_precharged, 1'b1);
    endtask
    task automatic calibrate();
        int n;
        repeat (30) begin
            @(negedge clk);
            chk(link.chip_sel && link.cmd == CMD_MRW, 1'b0);
        end
        cal_grant = 1'b1;
        next_cmd(20, n);
        chk({link.mode_addr, link.mode_data}, {MR_CALIBRATION, CAL_INIT_CODE});
        chk({cal_busy, ready}, 2'b10);
        for (int i = 0; i < 3; i++) begin
            next_cmd(60, n);
            if (i == 0) begin
                chk(n >= INITIAL_CAL_CYC && ready, 1'b1);
            end
            chk({link.mode_addr, link.mode_data}, {8'(i + 1), fv[i]});
            chk(in_training, 1'(i == 2));
        end
        wait_hi(1, 20, n);
        @(negedge clk);
        chk({in_idle, in_training}, 2'b10);
        chk(link.termination_control, odt0);
    endtask
    task automatic restart_trained();
        int n;
        need_training = 1'b1;
        restart = 1'b1;
        next_cmd(100, n);
        chk({link.cmd, link.mode_addr}, {CMD_MRW, MR_RESET});
        restart = 1'b0;
        repeat (400) begin
            @(negedge clk);
            if (go()) chk(link.cmd, CMD_NOP);
        end
        chk({in_idle, in_training_phase, init_done, ready}, 4'b1100);
        training_done = 1'b1;
        next_cmd(20, n);
        chk(link.mode_addr, MR_CALIBRATION);
        wait_hi(1, 200, n);
        chk(ready, 1'b1);
    endtask
    initial begin
        rst = 1'b1;
        supplies_ok = 1'b0;
        restart = 1'b0;
        need_training = 1'b0;
        training_done = 1'b0;
        cal_grant = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        power_up();
        auto_init();
        calibrate();
        restart_trained();
        summarize();
    end
endmodule
`default_nettype wire

/* include/init_link_if.sv */
// Command link between controller and memory device
`timescale 1ns/10ps
`default_nettype none
interface init_link_if;
    import init_seq_pkg::*;
    logic       clk_en;
    logic       chip_sel;
    cmd_type    cmd;
    logic [7:0] mode_addr;
    logic [7:0] mode_data;
    logic       termination_control;
    logic [7:0] read_data;
    logic       read_valid;
    logic       out_en;
    logic       burst_busy;

    modport device (
        input  clk_en,
        input  chip_sel,
        input  cmd,
        input  mode_addr,
        input  mode_data,
        input  termination_control,
        output read_data,
        output read_valid,
        output out_en,
        output burst_busy
    );

    modport controller (
        output clk_en,
        output chip_sel,
        output cmd,
        output mode_addr,
        output mode_data,
        output termination_control,
        input  read_data,
        input  read_valid,
        input  out_en,
        input  burst_busy
    );
endinterface
`default_nettype wire

/* include/init_seq_pkg.sv */
// Shared constants, mode registers and commands for the power-up initialization link
package init_seq_pkg;

    localparam int unsigned CLK_PERIOD_NS = 40;

    // Timing figures in their own units
    localparam int unsigned POST_RAMP_LOW_TIME_NS  = 100;
    localparam int unsigned STABLE_CLOCK_TIME_TCK  = 5;
    localparam int unsigned FIRST_NOP_TIME_US      = 200;
    localparam int unsigned POST_RESET_WAIT_US     = 1;
    localparam int unsigned AUTO_INIT_MAX_TIME_US  = 10;
    localparam int unsigned INITIAL_CAL_TIME_US    = 1;
    localparam int unsigned BOOT_CLOCK_PERIOD_MIN_NS = 18;
    localparam int unsigned BOOT_CLOCK_PERIOD_MAX_NS = 100;

    // Cycle counts: least times round up, longest times round down
    localparam int unsigned POST_RAMP_LOW_CYC  = (POST_RAMP_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STABLE_CLOCK_CYC   = STABLE_CLOCK_TIME_TCK;
    localparam int unsigned FIRST_NOP_CYC      = (FIRST_NOP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned POST_RESET_CYC     = (POST_RESET_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AUTO_INIT_MAX_CYC  = (AUTO_INIT_MAX_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned INITIAL_CAL_CYC    = (INITIAL_CAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned CNT_W = 13;

    // Mode register addresses and fields
    localparam logic [7:0] MR_DEVICE_INFO = 8'h00;
    localparam logic [7:0] MR_FEATURE1    = 8'h01;
    localparam logic [7:0] MR_FEATURE2    = 8'h02;
    localparam logic [7:0] MR_IO_CONFIG   = 8'h03;
    localparam logic [7:0] MR_CALIBRATION = 8'h0A;
    localparam logic [7:0] MR_CA_TRAIN1   = 8'h29;
    localparam logic [7:0] MR_CA_TRAIN2   = 8'h2A;
    localparam logic [7:0] MR_CA_TRAIN3   = 8'h30;
    localparam logic [7:0] MR_WR_LEVEL    = 8'h02;
    localparam logic [7:0] MR_RESET       = 8'h3F;
    localparam int unsigned AUTO_INIT_FLAG_BIT = 0;
    localparam int unsigned WR_LEVEL_BIT       = 7;
    localparam logic [7:0] CAL_INIT_CODE  = 8'hFF;
    localparam logic [7:0] MR0_RESET_VAL  = 8'h01;

    typedef enum logic [3:0] {
        CMD_NOP       = 4'h0,
        CMD_MRW       = 4'h1,
        CMD_MRR       = 4'h2,
        CMD_PRE_ALL   = 4'h3,
        CMD_PD_ENTRY  = 4'h4,
        CMD_PD_EXIT   = 4'h5,
        CMD_ACTIVATE  = 4'h6,
        CMD_READ      = 4'h7,
        CMD_WRITE     = 4'h8,
        CMD_REFRESH   = 4'h9
    } cmd_type;

    localparam logic [3:0] BURST_BEATS = 4'h4;

endpackage

/* verilog/init_controller.sv */
// Controller end: power-up, reset, flag polling and calibration sequence
`timescale 1ns/10ps
`default_nettype none
module init_controller (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          supplies_ok,
    input  wire logic          restart,
    input  wire logic          need_training,
    input  wire logic          training_done,
    input  wire logic          cal_grant,
    input  wire logic [7:0]    feature1_val,
    input  wire logic [7:0]    feature2_val,
    input  wire logic [7:0]    io_config_val,
    init_link_if.controller    link,
    output var  logic          in_training_phase,
    output var  logic          cal_busy,
    output var  logic          init_done
);
    import init_seq_pkg::*;

    typedef enum logic [11:0] {
        C_RAMP     = 12'b000000000001,
        C_LOW      = 12'b000000000010,
        C_NOP      = 12'b000000000100,
        C_RESET    = 12'b000000001000,
        C_WAIT4    = 12'b000000010000,
        C_POLL     = 12'b000000100000,
        C_POLLWAIT = 12'b000001000000,
        C_TRAIN    = 12'b000010000000,
        C_CAL      = 12'b000100000000,
        C_CALWAIT  = 12'b001000000000,
        C_CONFIG   = 12'b010000000000,
        C_DONE     = 12'b100000000000
    } cstate_type;

    cstate_type       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] ai_reg, ai_next;
    logic [1:0]       cfg_reg, cfg_next;
    logic             cke_reg, cke_next;
    logic             cs_reg, cs_next;
    cmd_type          cmd_reg, cmd_next;
    logic [7:0]       ma_reg, ma_next;
    logic [7:0]       md_reg, md_next;
    logic             odt_reg;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 1'b1;
        ai_next    = (ai_reg == '1) ? ai_reg : ai_reg + 1'b1;
        cfg_next   = cfg_reg;
        cke_next   = cke_reg;
        cs_next    = 1'b0;
        cmd_next   = CMD_NOP;
        ma_next    = 8'h00;
        md_next    = 8'h00;
        case (state_reg)
            C_RAMP: begin
                cke_next = 1'b0;
                cnt_next = '0;
                if (supplies_ok)
                    state_next = C_LOW;
            end
            C_LOW: begin
                // Clock runs throughout, so both minimums share one count
                if (cnt_reg >= CNT_W'(POST_RAMP_LOW_CYC - 1) &&
                    cnt_reg >= CNT_W'(STABLE_CLOCK_CYC - 1)) begin
                    cke_next   = 1'b1;
                    cnt_next   = '0;
                    state_next = C_NOP;
                end
            end
            C_NOP: begin
                if (cnt_reg >= CNT_W'(FIRST_NOP_CYC - 1))
                    state_next = C_RESET;
            end
            C_RESET: begin
                cs_next    = 1'b1;
                cmd_next   = CMD_MRW;
                ma_next    = MR_RESET;
                cnt_next   = '0;
                ai_next    = '0;
                state_next = C_WAIT4;
            end
            C_WAIT4: begin
                if (cnt_reg >= CNT_W'(POST_RESET_CYC - 1))
                    state_next = need_training ? C_POLLWAIT : C_POLL;
            end
            C_POLL: begin
                // Flag polled only on an untrained bus; the 40 ns clock lies in the boot range
                cs_next    = 1'b1;
                cmd_next   = CMD_MRR;
                ma_next    = MR_DEVICE_INFO;
                state_next = C_POLLWAIT;
            end
            C_POLLWAIT: begin
                if (ai_reg >= CNT_W'(AUTO_INIT_MAX_CYC))
                    state_next = need_training ? C_TRAIN : C_CAL;
                else if (!need_training && link.read_valid) begin
                    if (!link.read_data[AUTO_INIT_FLAG_BIT])
                        state_next = C_CAL;
                    else
                        state_next = C_POLL;
                end
            end
            C_TRAIN: begin
                // Bus idles with no-operations until training completes
                if (training_done)
                    state_next = C_CAL;
            end
            C_CAL: begin
                if (cal_grant) begin
                    cs_next    = 1'b1;
                    cmd_next   = CMD_MRW;
                    ma_next    = MR_CALIBRATION;
                    md_next    = CAL_INIT_CODE;
                    cnt_next   = '0;
                    state_next = C_CALWAIT;
                end
            end
            C_CALWAIT: begin
                if (cnt_reg >= CNT_W'(INITIAL_CAL_CYC - 1)) begin
                    cfg_next   = 2'h0;
                    state_next = C_CONFIG;
                end
            end
            C_CONFIG: begin
                cs_next  = 1'b1;
                cmd_next = CMD_MRW;
                cfg_next = cfg_reg + 1'b1;
                case (cfg_reg)
                    2'h0: begin
                        ma_next = MR_FEATURE1;
                        md_next = feature1_val;
                    end
                    2'h1: begin
                        ma_next = MR_FEATURE2;
                        md_next = feature2_val;
                    end
                    default: begin
                        ma_next    = MR_IO_CONFIG;
                        md_next    = io_config_val;
                        state_next = C_DONE;
                    end
                endcase
            end
            C_DONE: begin
            end
            default: state_next = C_RAMP;
        endcase
        if (restart && state_reg == C_DONE && !link.burst_busy)
            state_next = C_RESET;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= C_RAMP;
            cnt_reg   <= '0;
            ai_reg    <= '0;
            cfg_reg   <= 2'h0;
            cke_reg   <= 1'b0;
            cs_reg    <= 1'b0;
            cmd_reg   <= CMD_NOP;
            ma_reg    <= 8'h00;
            md_reg    <= 8'h00;
            odt_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            ai_reg    <= ai_next;
            cfg_reg   <= cfg_next;
            cke_reg   <= cke_next;
            cs_reg    <= cs_next;
            cmd_reg   <= cmd_next;
            ma_reg    <= ma_next;
            md_reg    <= md_next;
            odt_reg   <= 1'b0;
        end
    end

    assign link.clk_en              = cke_reg;
    assign link.chip_sel            = cs_reg;
    assign link.cmd                 = cmd_reg;
    assign link.mode_addr           = ma_reg;
    assign link.mode_data           = md_reg;
    assign link.termination_control = odt_reg;
    // One-hot state bits read straight from the state register
    assign in_training_phase        = state_reg[7];
    assign cal_busy                 = state_reg[9];
    assign init_done                = state_reg[11];
endmodule
`default_nettype wire

/* verilog/init_device.sv */
// Memory device end: bus state machine, reset and auto-initialization
`timescale 1ns/10ps
`default_nettype none
module init_device (
    input  wire logic          clk,
    input  wire logic          rst,
    init_link_if.device        link,
    output var  logic          in_idle,
    output var  logic          ready,
    output var  logic          all_precharged,
    output var  logic          in_training
);
    import init_seq_pkg::*;

    typedef enum logic [5:0] {
        D_OFF      = 6'b000001,
        D_AUTOINIT = 6'b000010,
        D_IDLE     = 6'b000100,
        D_TRAIN    = 6'b001000,
        D_ACTIVE   = 6'b010000,
        D_BURST    = 6'b100000
    } dstate_type;

    dstate_type       state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] cal_reg, cal_next;
    logic [3:0]       beat_reg, beat_next;
    logic             flag_reg, flag_next;
    logic             cal_run_reg, cal_run_next;
    logic             ready_reg, ready_next;
    logic [7:0]       rd_reg, rd_next;
    logic             rv_reg, rv_next;
    logic             oe_reg, oe_next;
    logic             prech_reg, prech_next;

    logic cmd_valid;
    logic mrw_reset;
    logic mrw_train;
    assign cmd_valid = link.clk_en && link.chip_sel;
    assign mrw_reset = cmd_valid && link.cmd == CMD_MRW && link.mode_addr == MR_RESET;
    assign mrw_train = cmd_valid && link.cmd == CMD_MRW &&
                       (link.mode_addr == MR_CA_TRAIN1 || link.mode_addr == MR_CA_TRAIN2 ||
                        link.mode_addr == MR_CA_TRAIN3 ||
                        (link.mode_addr == MR_WR_LEVEL && link.mode_data[WR_LEVEL_BIT]));

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        cal_next     = cal_reg;
        beat_next    = beat_reg;
        flag_next    = flag_reg;
        cal_run_next = cal_run_reg;
        ready_next   = ready_reg;
        rd_next      = rd_reg;
        rv_next      = 1'b0;
        prech_next   = prech_reg;
        oe_next      = link.clk_en;
        if (mrw_reset) begin
            state_next   = D_AUTOINIT;
            cnt_next     = '0;
            flag_next    = MR0_RESET_VAL[AUTO_INIT_FLAG_BIT];
            ready_next   = 1'b0;
            cal_run_next = 1'b0;
            prech_next   = 1'b1;
        end else begin
            case (state_reg)
                D_OFF: begin
                    prech_next = 1'b1;
                end
                D_AUTOINIT: begin
                    cnt_next = cnt_reg + 1'b1;
                    // Flag clears and idle is reached by the maximum time
                    if (cnt_reg >= CNT_W'(AUTO_INIT_MAX_CYC - 1)) begin
                        flag_next  = 1'b0;
                        state_next = D_IDLE;
                    end
                end
                D_IDLE: begin
                    prech_next = 1'b1;
                    if (mrw_train)
                        state_next = D_TRAIN;
                    else if (cmd_valid && link.cmd == CMD_ACTIVATE) begin
                        state_next = D_ACTIVE;
                        prech_next = 1'b0;
                    end
                end
                D_TRAIN: begin
                    // Leaves only on a further mode register write
                    if (cmd_valid && link.cmd == CMD_MRW && !mrw_train)
                        state_next = D_IDLE;
                end
                D_ACTIVE: begin
                    if (cmd_valid && (link.cmd == CMD_READ || link.cmd == CMD_WRITE)) begin
                        state_next = D_BURST;
                        beat_next  = BURST_BEATS;
                    end else if (cmd_valid && link.cmd == CMD_PRE_ALL) begin
                        // Banks report precharged in the same cycle idle is entered
                        state_next = D_IDLE;
                        prech_next = 1'b1;
                    end
                end
                D_BURST: begin
                    beat_next = beat_reg - 1'b1;
                    if (beat_reg == 4'h1)
                        state_next = D_ACTIVE;
                end
                default: state_next = D_OFF;
            endcase
            // Initial calibration write starts the ready timer
            if (cmd_valid && link.cmd == CMD_MRW && link.mode_addr == MR_CALIBRATION &&
                state_reg == D_IDLE) begin
                cal_run_next = 1'b1;
                cal_next     = '0;
            end else if (cal_run_reg) begin
                cal_next = cal_reg + 1'b1;
                if (cal_reg >= CNT_W'(INITIAL_CAL_CYC - 1)) begin
                    ready_next   = 1'b1;
                    cal_run_next = 1'b0;
                end
            end
            // Only mode register reads answer; others are ignored here
            if (cmd_valid && link.cmd == CMD_MRR && state_reg != D_OFF) begin
                rv_next = 1'b1;
                rd_next = (link.mode_addr == MR_DEVICE_INFO) ?
                          {7'h00, flag_reg} : 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= D_OFF;
            cnt_reg     <= '0;
            cal_reg     <= '0;
            beat_reg    <= '0;
            flag_reg    <= MR0_RESET_VAL[AUTO_INIT_FLAG_BIT];
            cal_run_reg <= 1'b0;
            ready_reg   <= 1'b0;
            rd_reg      <= 8'h00;
            rv_reg      <= 1'b0;
            oe_reg      <= 1'b0;
            prech_reg   <= 1'b1;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            cal_reg     <= cal_next;
            beat_reg    <= beat_next;
            flag_reg    <= flag_next;
            cal_run_reg <= cal_run_next;
            ready_reg   <= ready_next;
            rd_reg      <= rd_next;
            rv_reg      <= rv_next;
            oe_reg      <= oe_next;
            prech_reg   <= prech_next;
        end
    end

    assign link.read_data  = rd_reg;
    assign link.read_valid = rv_reg;
    assign link.out_en     = oe_reg;
    // burst_busy, in_idle and in_training read straight from one-hot state bits; ready and all_precharged from their registers
    assign link.burst_busy = state_reg[5];
    assign in_idle         = state_reg[2];
    assign in_training     = state_reg[3];
    assign ready           = ready_reg;
    assign all_precharged  = prech_reg;
endmodule
`default_nettype wire
